// *** frsp_consts.vh ***
// Purpose: constants for the serial memory slave port
// Assumes: included by its bare name from the design files
// Notes: command codes and status bit positions are plain defaults
`ifndef FRSP_CONSTS_VH
`define FRSP_CONSTS_VH

// array geometry
`define FRSP_DEPTH 2048
`define FRSP_AW 11
`define FRSP_ADDR_LAST 11'h7FF
`define FRSP_QUARTER_BASE 11'h600
`define FRSP_HALF_BASE 11'h400

// command codes
`define FRSP_CMD_WEN_SET 8'h06
`define FRSP_CMD_WEN_CLR 8'h04
`define FRSP_CMD_STAT_RD 8'h05
`define FRSP_CMD_STAT_WR 8'h01
`define FRSP_CMD_MEM_RD 8'h03
`define FRSP_CMD_MEM_WR 8'h02

// status register layout
`define FRSP_ST_HONOUR 7
`define FRSP_ST_BP_HI 3
`define FRSP_ST_BP_LO 2
`define FRSP_ST_WEL 1
`define FRSP_ST_WMASK 8'h8C
`define FRSP_ST_RESET 8'h00

// block protection codes
`define FRSP_BP_NONE 2'h0
`define FRSP_BP_QUARTER 2'h1
`define FRSP_BP_HALF 2'h2
`define FRSP_BP_ALL 2'h3

// synchroniser width and last bit index of a byte
`define FRSP_SYNC_W 5
`define FRSP_BIT_LAST 3'h7
// pins at reset: select high, clock low, pause and protect high
`define FRSP_PIN_RESET 5'h13
`endif

// *** frsp_slave.v ***
// Purpose: slave side of a serial memory port with a 2048 x 8 array
// Assumes: bit clock is sampled by CLK_I, so it must run well below CLK_I / 4
// Notes: the synchronous reset stands in for the internal power-on reset
// What this block does
// - array of 2048 bytes, each eight bits, addressed one at a time.
// - works in clock-idle-low and clock-idle-high modes; master uses one of them.
// - select high means standby, other inputs ignored, output tristated.
// - input bits taken on rising bit-clock edges, output changes on falling.
// - bit clock may run slow or stop; transfer state is kept meanwhile.
// - serial input only matters at rising bit-clock edges.
// - output driven only while returning read data, never while paused.
// - honour bit set and protect pin low refuse status register writes.
// - pause low suspends the operation, bit clock and select ignored.
// - each data byte commits on its last bit, with no busy state.
// - block protection guards upper quarter, upper half or whole array.
// - first byte after select falls is the command code.
// - two address bytes; only the low 11 bits select the byte.
// - everything shifts most significant bit first.
// - unknown command: ignore input until next select fall, output off.
`timescale 1ns/1ps
`include "frsp_consts.vh"
module frsp_slave (
   input wire CLK_I,          // system clock, 20 MHz
   input wire RESET_N_I,      // synchronous reset, active low
   input wire CS_N_I,         // device select pin, active low
   input wire SCK_I,          // bit clock pin from the master
   input wire SI_I,           // serial data from the master
   input wire HOLD_N_I,       // pause pin, active low
   input wire WP_N_I,         // write-protect pin, active low
   output wire SO_O,          // serial data to the master
   output wire SO_OE_O,       // high while the output is driven
   output wire STANDBY_O,     // high while the device is deselected
   output wire [7:0] STATUS_O // current status register
);
   ////////////////////////////////////////////////////////////////////////
   // states
   localparam [3:0] S_CMD = 4'h0;
   localparam [3:0] S_AHI = 4'h1;
   localparam [3:0] S_ALO = 4'h2;
   localparam [3:0] S_MRD = 4'h3;
   localparam [3:0] S_MWR = 4'h4;
   localparam [3:0] S_SWR = 4'h5;
   localparam [3:0] S_SRD = 4'h6;
   localparam [3:0] S_IGN = 4'h7;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   wire [4:0] pin_s;
   wire cs_n_s;
   wire sck_s;
   wire si_s;
   wire hold_n_s;
   wire wp_n_s;

   // pins start at idle so no false clock edge follows reset
   frsp_sync #(
      .WIDTH(`FRSP_SYNC_W),
      .INIT(`FRSP_PIN_RESET)
   ) u_sync (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .async_i({CS_N_I, SCK_I, SI_I, HOLD_N_I, WP_N_I}),
      .sync_o(pin_s)
   );

   assign cs_n_s = pin_s[4];
   assign sck_s = pin_s[3];
   assign si_s = pin_s[2];
   assign hold_n_s = pin_s[1];
   assign wp_n_s = pin_s[0];

   ////////////////////////////////////////////////////////////////////////
   // storage and control registers
   reg [7:0] mem [0:`FRSP_DEPTH-1];
   reg [7:0] status_reg;
   reg [7:0] status_next;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [2:0] bit_reg;
   reg [2:0] bit_next;
   reg [6:0] shift_reg;
   reg [6:0] shift_next;
   reg [`FRSP_AW-1:0] addr_reg;
   reg [`FRSP_AW-1:0] addr_next;
   reg [7:0] tx_reg;
   reg [7:0] tx_next;
   reg so_reg;
   reg so_next;
   reg drive_reg;
   reg drive_next;
   reg wr_cmd_reg;
   reg wr_cmd_next;
   reg clr_wel_reg;
   reg clr_wel_next;
   reg cs_act_reg;
   reg sck_prev_reg;
   reg mem_we;
   reg [7:0] byte_in;

   ////////////////////////////////////////////////////////////////////////
   // block protection decode
   function prot_hit;
      input [1:0] bp;
      input [`FRSP_AW-1:0] a;
      begin
         case (bp)
            `FRSP_BP_QUARTER: prot_hit = (a >= `FRSP_QUARTER_BASE);
            `FRSP_BP_HALF: prot_hit = (a >= `FRSP_HALF_BASE);
            `FRSP_BP_ALL: prot_hit = 1'b1;
            default: prot_hit = 1'b0;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // states in which read data goes out on the serial line
   function drives_out;
      input [3:0] s;
      begin
         drives_out = (s == S_MRD) || (s == S_SRD);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // edge detection, gated by pause and select
   wire paused = ~hold_n_s;
   wire selected = ~cs_act_reg;
   // only transitions count, so the clock may idle low or high
   wire sck_rise = sck_s & ~sck_prev_reg & selected & ~paused;
   wire sck_fall = ~sck_s & sck_prev_reg & selected & ~paused;
   wire byte_done = sck_rise & (bit_reg == `FRSP_BIT_LAST);
   wire st_locked = status_reg[`FRSP_ST_HONOUR] & ~wp_n_s;
   wire wel = status_reg[`FRSP_ST_WEL];
   wire [`FRSP_AW-1:0] addr_inc = addr_reg + 11'h001;

   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         cs_act_reg <= 1'b1;
         sck_prev_reg <= 1'b0;
      end else begin
         // select changes are frozen while paused
         if (hold_n_s) begin
            cs_act_reg <= cs_n_s;
         end
         // previous level always tracks, so a resume sees no false edge
         sck_prev_reg <= sck_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command, address and data sequencing
   always @* begin
      state_next = state_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      addr_next = addr_reg;
      tx_next = tx_reg;
      so_next = so_reg;
      drive_next = drive_reg;
      wr_cmd_next = wr_cmd_reg;
      clr_wel_next = clr_wel_reg;
      status_next = status_reg;
      mem_we = 1'b0;
      byte_in = {shift_reg, si_s};
      if (!selected) begin
         // standby: every transfer restarts on the next select fall
         state_next = S_CMD;
         bit_next = 3'h0;
         drive_next = 1'b0;
         so_next = 1'b0;
         wr_cmd_next = 1'b0;
         clr_wel_next = 1'b0;
         if (clr_wel_reg) begin
            status_next[`FRSP_ST_WEL] = 1'b0;
         end
      end else if (sck_fall) begin
         if (drives_out(state_reg)) begin
            so_next = tx_reg[`FRSP_BIT_LAST - bit_reg];
            drive_next = 1'b1;
         end
      end else if (sck_rise) begin
         shift_next = byte_in[6:0];
         bit_next = bit_reg + 3'h1;
         if (bit_reg == `FRSP_BIT_LAST) begin
            case (state_reg)
               S_CMD: begin
                  // first byte of a select period is the command
                  case (byte_in)
                     `FRSP_CMD_WEN_SET: begin
                        status_next[`FRSP_ST_WEL] = 1'b1;
                        state_next = S_IGN;
                     end
                     `FRSP_CMD_WEN_CLR: begin
                        status_next[`FRSP_ST_WEL] = 1'b0;
                        state_next = S_IGN;
                     end
                     `FRSP_CMD_STAT_RD: begin
                        tx_next = status_reg;
                        state_next = S_SRD;
                     end
                     `FRSP_CMD_STAT_WR: begin
                        state_next = S_SWR;
                     end
                     `FRSP_CMD_MEM_RD: begin
                        wr_cmd_next = 1'b0;
                        state_next = S_AHI;
                     end
                     `FRSP_CMD_MEM_WR: begin
                        wr_cmd_next = 1'b1;
                        state_next = S_AHI;
                     end
                     default: begin
                        state_next = S_IGN;
                     end
                  endcase
               end
               S_AHI: begin
                  // upper five address bits are don't care
                  addr_next = {byte_in[2:0], addr_reg[7:0]};
                  state_next = S_ALO;
               end
               S_ALO: begin
                  addr_next = {addr_reg[10:8], byte_in};
                  tx_next = mem[{addr_reg[10:8], byte_in}];
                  state_next = wr_cmd_reg ? S_MWR : S_MRD;
               end
               S_MRD: begin
                  addr_next = addr_inc;
                  tx_next = mem[addr_inc];
               end
               S_MWR: begin
                  // commit on the last bit, nothing to poll afterwards
                  mem_we = wel & ~prot_hit(status_reg[3:2], addr_reg);
                  addr_next = addr_inc;
                  clr_wel_next = 1'b1;
               end
               S_SWR: begin
                  if (wel && !st_locked) begin
                     status_next = (byte_in & `FRSP_ST_WMASK) |
                                   (status_reg & ~`FRSP_ST_WMASK);
                  end
                  clr_wel_next = 1'b1;
                  state_next = S_IGN;
               end
               S_SRD: begin
                  tx_next = status_reg;
               end
               S_IGN: begin
                  // stay deaf until select rises again
                  state_next = S_IGN;
               end
               default: begin
                  state_next = S_IGN;
               end
            endcase
         end
      end
   end

   always @(posedge CLK_I) begin
      if (!RESET_N_I) begin
         state_reg <= S_CMD;
         bit_reg <= 3'h0;
         shift_reg <= 7'h00;
         addr_reg <= 11'h000;
         tx_reg <= 8'h00;
         so_reg <= 1'b0;
         drive_reg <= 1'b0;
         wr_cmd_reg <= 1'b0;
         clr_wel_reg <= 1'b0;
         status_reg <= `FRSP_ST_RESET;
      end else begin
         // registers load every cycle, but edges are gated while paused, so state holds across pauses
         state_reg <= state_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         addr_reg <= addr_next;
         tx_reg <= tx_next;
         so_reg <= so_next;
         drive_reg <= drive_next;
         wr_cmd_reg <= wr_cmd_next;
         clr_wel_reg <= clr_wel_next;
         status_reg <= status_next;
      end
   end

   // array itself is not reset: contents are nonvolatile
   always @(posedge CLK_I) begin
      if (mem_we) begin
         mem[addr_reg] <= byte_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign SO_O = so_reg;
   assign SO_OE_O = selected & hold_n_s & drive_reg & drives_out(state_reg);
   assign STANDBY_O = cs_act_reg;
   assign STATUS_O = status_reg;
endmodule

// *** frsp_slave_chk.sv ***
// Purpose: pin assertions for the serial memory slave port
// Assumes: pins reach the logic through two flops on CLK_I
// Notes: bound to frsp_slave at the foot of this file
`timescale 1ns/1ps
module frsp_slave_chk (
   input wire CLK_I,          // system clock
   input wire RESET_N_I,      // reset, active low
   input wire CS_N_I,         // select pin
   input wire SCK_I,          // bit clock pin
   input wire SI_I,           // serial in
   input wire HOLD_N_I,       // pause pin
   input wire WP_N_I,         // protect pin
   input wire SO_O,           // serial out
   input wire SO_OE_O,        // output enable
   input wire STANDBY_O,      // standby flag
   input wire [7:0] STATUS_O  // status register
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESET_N_I);
   property p_stby; (CS_N_I && HOLD_N_I) [*5] |-> STANDBY_O; endproperty
   a_stby: assert property (p_stby) else $error("no standby");
   property p_act; (!CS_N_I && HOLD_N_I) [*5] |-> !STANDBY_O; endproperty
   a_act: assert property (p_act) else $error("stuck in standby");
   property p_oe_stby; CS_N_I [*4] |-> !SO_OE_O; endproperty
   a_oe_stby: assert property (p_oe_stby) else $error("driven in standby");
   property p_oe_hold; (!HOLD_N_I) [*3] |-> !SO_OE_O; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("driven while paused");
   property p_so_fall; SO_OE_O && $changed(SO_O) |-> !SCK_I; endproperty
   a_so_fall: assert property (p_so_fall) else $error("output moved off a fall");
   property p_oe_rise; $rose(SO_OE_O) |-> !SCK_I; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("enable rose off a fall");
   property p_stat; STANDBY_O [*4] |=> $stable(STATUS_O); endproperty
   a_stat: assert property (p_stat) else $error("status moved in standby");
   property p_wp; (!WP_N_I && STATUS_O[7]) [*4] |=> $stable(STATUS_O[7:2]); endproperty
   a_wp: assert property (p_wp) else $error("guarded status written");
   c_read: cover property ($rose(SO_OE_O));
   c_hold: cover property (!HOLD_N_I && !CS_N_I);
   c_guard: cover property (!WP_N_I && STATUS_O[7]);
endmodule
bind frsp_slave frsp_slave_chk i_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
   .CS_N_I(CS_N_I), .SCK_I(SCK_I), .SI_I(SI_I), .HOLD_N_I(HOLD_N_I), .WP_N_I(WP_N_I),
   .SO_O(SO_O), .SO_OE_O(SO_OE_O), .STANDBY_O(STANDBY_O), .STATUS_O(STATUS_O));

// *** frsp_spi_master.sv ***
// Purpose: serial bus master model driving the slave port
// Assumes: 400 ns bit clock, stepped 1 ns after CLK_I edges
// Notes: cpol picks idle level, hold_bit pauses inside every byte
`timescale 1ns/1ps
module frsp_spi_master (
   input wire clk_i,         // time base
   input wire miso_i,        // resolved output line
   output logic cs_n_o = 1,  // select
   output logic sck_o = 0,   // bit clock
   output logic si_o = 0,    // serial data
   output logic hold_n_o = 1 // pause
);
   bit cpol;
   int hold_bit = -1;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic sel();
      sck_o <= cpol; // idle level of the mode
      tick(4);
      cs_n_o <= 0; // fresh select fall per command
      tick(4);
   endtask
   task automatic desel();
      if (!cpol) sck_o <= 0;
      tick(4);
      cs_n_o <= 1;
      si_o <= ~si_o;
      tick(4);
   endtask
   ////////////////////////////////////////
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_o <= 0;
         si_o <= tx[i];
         tick(4);
         if (i == hold_bit) begin // pause moves only with clock low
            hold_n_o <= 0;
            tick(4);
            sck_o <= 1;
            cs_n_o <= 1;
            tick(4);
            sck_o <= 0;
            cs_n_o <= 0;
            tick(4);
            hold_n_o <= 1;
            tick(4);
         end
         sck_o <= 1;
         tick(2);
         rx[i] = miso_i;
         si_o <= ~tx[i]; // junk between rising edges
         tick(2);
      end
   endtask
endmodule

// *** frsp_sync.v ***
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous to CLK_I
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module frsp_sync #(
   parameter WIDTH = 5,
   parameter [WIDTH-1:0] INIT = 5'h1F
) (
   input wire clk_i,                // system clock
   input wire reset_n_i,            // synchronous reset, active low
   input wire [WIDTH-1:0] async_i,  // raw pin levels
   output wire [WIDTH-1:0] sync_o   // synchronised levels
);
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         stage1_reg <= INIT;
         stage2_reg <= INIT;
      end else begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_o = stage2_reg;
endmodule

// *** test_spi_fram_slave_port.sv ***
// Purpose: self-checking bench for the serial memory slave port
// Assumes: master model makes the bit clock
// Notes: reference array and status kept here
`timescale 1ns/1ps
module test_spi_fram_slave_port;
   logic clk = 0;
   logic rst_n = 0;
   logic wp_n = 1;
   logic flip = 0;
   logic oe_seen = 0;
   logic cs_n, sck, si, hold_n, so, so_oe, stby;
   logic [7:0] status;
   logic [7:0] st = 8'h00;
   logic [7:0] mdl [0:2047];
   int failures = 0;
   int samples_checked = 0;
   wire miso = so_oe ? so : flip;
   always #25 clk = ~clk;
   always @(posedge clk) flip <= ~flip;
   always @(posedge clk) if (so_oe) oe_seen <= 1;
   frsp_slave i_frsp_slave (.CLK_I(clk), .RESET_N_I(rst_n), .CS_N_I(cs_n), .SCK_I(sck),
      .SI_I(si), .HOLD_N_I(hold_n), .WP_N_I(wp_n), .SO_O(so), .SO_OE_O(so_oe),
      .STANDBY_O(stby), .STATUS_O(status));
   frsp_spi_master u_mst (.clk_i(clk), .miso_i(miso), .cs_n_o(cs_n), .sck_o(sck),
      .si_o(si), .hold_n_o(hold_n));
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   function automatic bit prot(input logic [10:0] a);
      return st[3:2] == 2'h3 || (st[3:2] == 2'h2 && a >= 11'h400)
         || (st[3:2] == 2'h1 && a >= 11'h600);
   endfunction
   task automatic go(input logic [7:0] op);
      logic [7:0] r;
      oe_seen = 0;
      u_mst.sel();
      u_mst.xb(op, r);
   endtask
   task automatic done(input bit quiet);
      u_mst.desel();
      chk(status, st);
      if (quiet) chk({7'h00, oe_seen}, 8'h00);
   endtask
   task automatic one(input logic [7:0] op);
      logic [7:0] r;
      go(op);
      if (op != 8'h06) u_mst.xb(8'($urandom), r);
      if (op == 8'h05) chk(r, st);
      if (op == 8'h06) st[1] = 1;
      done(op != 8'h05);
   endtask
   task automatic wrsr(input logic [7:0] v);
      logic [7:0] r;
      go(8'h01);
      u_mst.xb(v, r);
      if (st[1] && !(st[7] && !wp_n)) st = (st & 8'h73) | (v & 8'h8C);
      st[1] = 0;
      done(1);
   endtask
   task automatic mem(input logic [7:0] op, input logic [15:0] a, input int n);
      logic [7:0] d, r;
      go(op);
      u_mst.xb(a[15:8], r);
      u_mst.xb(a[7:0], r);
      repeat (n) begin
         d = 8'($urandom);
         u_mst.xb(d, r);
         if (op == 8'h03) chk(r, mdl[a[10:0]]);
         else if (st[1] && !prot(a[10:0])) mdl[a[10:0]] = d;
         a = a + 16'h0001;
      end
      if (op == 8'h02) st[1] = 0;
      done(op == 8'h02);
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      void'($urandom(32'hd7ff));
      u_mst.tick(6);
      rst_n = 1;
      chk(status, 8'h00);
      chk({7'h00, stby}, 8'h01);
      for (int m = 0; m < 2; m++) begin
         u_mst.cpol = m[0];
         u_mst.hold_bit = m ? 3 : -1;
         one(8'h06);
         mem(8'h02, 16'hF7FE, 4);
         mem(8'h03, 16'hF7FE, 4);
         one(8'h05);
      end
      u_mst.hold_bit = -1;
      // write enable is clear: this byte must not land, read back later
      mem(8'h02, 16'hA7FF, 1);
      for (int i = 0; i < 2; i++) begin
         one(8'h06);
         mem(8'h02, i ? 16'h05FF : 16'h03FF, 2);
      end
      for (int b = 0; b < 4; b++) begin
         one(8'h06);
         wrsr({4'h0, b[1:0], 2'b00});
         one(8'h06);
         mem(8'h02, (b == 1) ? 16'h05FF : (b == 3) ? 16'h07FF : 16'h03FF, 2);
         mem(8'h03, (b == 1) ? 16'h05FF : (b == 3) ? 16'h07FF : 16'h03FF, 2);
      end
      for (int k = 0; k < 3; k++) begin
         wp_n = (k != 1);
         u_mst.tick(4);
         one(8'h06);
         wrsr(k ? 8'h00 : 8'h8C);
         one(8'h05);
      end
      one(8'hA7);
      conclude();
   end
endmodule
